// [src/lms_master.sv]
`timescale 1ns/1ps
`include "lms_regs.svh"

// Function
// - Store data appears with the start strobe and holds until ready is seen.
// - Only selected lanes carry write data; other lanes are don't-care.
// - Start strobe is high only in a transfer's first cycle.
// - Read strobe rises at transfer start and falls the cycle after ready.
// - A read following ready directly keeps the read strobe high.
// - Write strobe rises at transfer start and falls the cycle after ready.
// - A write following ready directly keeps the write strobe high.
// - Ready at a rising edge ends the transfer; next may start next cycle.
// - All local bus signalling runs on the single core clock.
// - Byte/half/word to 32-bit, byte/half to 16-bit, byte to 8-bit targets.
// - Transfers wider than the target are refused, never split.
// - Lane selects come from size and the two low address bits.
// - Loads move the selected lanes to the low end of the result.
// - Steering has no left-justify mode: narrow targets get data on the lanes their address selects.
// - Data side peripheral or both; instruction side local, both or peripheral.
// - Presence options are 0/1 parameters defaulting to 1; barrel defaults 0.
// - Address and lane selects stay valid while the start strobe is high.
// - Every local bus signal is active high.
module lms_master #(
  parameter bit dside_periph_present = 1'b1,
  parameter bit dside_local_present = 1'b1,
  parameter bit iside_periph_present = 1'b1,
  parameter bit iside_local_present = 1'b1,
  parameter bit use_barrel = 1'b0
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [31:0] d_addr,
  output logic [3:0] d_lane_sel,
  output logic [`LMS_DATA_W-1:0] d_wdata,
  output logic d_transfer_start_strobe,
  output logic d_rd_strobe,
  output logic d_wr_strobe,
  input wire logic [`LMS_DATA_W-1:0] d_rdata,
  input wire logic d_ready,
  output logic [31:0] i_addr,
  output logic i_transfer_start_strobe,
  output logic i_fetch_strobe,
  input wire logic [`LMS_DATA_W-1:0] i_rdata,
  input wire logic i_ready
);

  // ----------------------------------------
  // APB slave
  // ----------------------------------------
  logic pready_q;
  logic pslverr_q;
  logic [31:0] prdata_q;
  wire logic apb_access = psel & penable & ~pready_q;
  wire logic apb_take = psel & penable & pready_q;
  wire logic sel_addr = (paddr == `LMS_OFF_ADDR);
  wire logic sel_wdata = (paddr == `LMS_OFF_WDATA);
  wire logic sel_ctrl = (paddr == `LMS_OFF_CTRL);
  wire logic sel_status = (paddr == `LMS_OFF_STATUS);
  wire logic sel_load = (paddr == `LMS_OFF_LOAD);
  wire logic sel_config = (paddr == `LMS_OFF_CONFIG);
  wire logic hit = sel_addr | sel_wdata | sel_ctrl | sel_status | sel_load | sel_config;
  // Writes land at the edge the master sees ready
  wire logic wr_take = apb_take & pwrite & hit;
  wire logic [31:0] clr = (wr_take & sel_status) ? pwdata : 32'h0000_0000;

  // ----------------------------------------
  // Software registers
  // ----------------------------------------
  logic [31:0] addr_q;
  logic [31:0] wdata_q;
  logic [31:0] load_q;
  logic pend_q;
  lms_pkg::lms_cmd_s pend_cmd_q;
  logic done_q;
  logic refused_q;
  lms_pkg::lms_state_e state_q;
  lms_pkg::lms_state_e state_d;
  logic cur_iside_q;
  logic cur_wr_q;
  logic [1:0] cur_lo_q;
  lms_pkg::lms_size_t cur_size_q;

  wire lms_pkg::lms_cmd_s new_cmd = '{
    iside: pwdata[`LMS_CTRL_ISIDE],
    tgt: pwdata[`LMS_CTRL_TGT+:2],
    size: pwdata[`LMS_CTRL_SIZE+:2],
    wr: pwdata[`LMS_CTRL_WR]
  };
  // One-deep slot: lets a transfer launch right at the previous ready
  wire logic go_req = wr_take & sel_ctrl & pwdata[`LMS_CTRL_GO];
  wire logic go_accept = go_req & ~pend_q;
  wire logic go_refuse = go_req & pend_q;

  // ----------------------------------------
  // Transfer sequencing
  // ----------------------------------------
  wire logic busy = (state_q == lms_pkg::LMS_XFER);
  wire logic cur_ready = cur_iside_q ? i_ready : d_ready;
  wire logic done_now = busy & cur_ready;
  wire logic slot_free = ~busy | done_now;
  wire logic launch = pend_q & slot_free;
  // Data side without a local port is peripheral only here
  wire logic side_missing = pend_cmd_q.iside ? ~iside_local_present : ~dside_local_present;
  lms_steer_if sif ();
  wire logic launch_bad = launch & (sif.bad | side_missing |
    (pend_cmd_q.iside & pend_cmd_q.wr));
  wire logic launch_ok = launch & ~launch_bad;
  wire logic launch_d = launch_ok & ~pend_cmd_q.iside;
  wire logic launch_rd = launch_d & ~pend_cmd_q.wr;
  wire logic launch_wr = launch_d & pend_cmd_q.wr;
  wire logic launch_i = launch_ok & pend_cmd_q.iside;

  assign sif.cmd_lo = addr_q[1:0];
  assign sif.cmd_size = pend_cmd_q.iside ? `LMS_SIZE_WORD : pend_cmd_q.size;
  assign sif.cmd_tgt = pend_cmd_q.iside ? `LMS_TGT_W32 : pend_cmd_q.tgt;
  assign sif.store_src = wdata_q;
  assign sif.rsp_lo = cur_lo_q;
  assign sif.rsp_size = cur_size_q;
  assign sif.rsp_lanes = cur_iside_q ? i_rdata : d_rdata;

  lms_steer u_steer (
    .sif(sif)
  );

  always_comb
  begin
    case (state_q)
      lms_pkg::LMS_IDLE: state_d = launch_ok ? lms_pkg::LMS_XFER : lms_pkg::LMS_IDLE;
      lms_pkg::LMS_XFER: state_d = (done_now & ~launch_ok) ? lms_pkg::LMS_IDLE : lms_pkg::LMS_XFER;
      default: state_d = lms_pkg::LMS_IDLE;
    endcase
  end

  // ----------------------------------------
  // Read mux
  // ----------------------------------------
  wire logic [31:0] status_word = {28'h000_0000, pend_q, refused_q, done_q, busy};
  wire logic [31:0] ctrl_word = {25'h000_0000, pend_cmd_q, pend_q};
  wire logic [31:0] config_word = {16'h0000, 8'(`LMS_DATA_W), 3'h0, use_barrel,
    iside_periph_present, iside_local_present, dside_periph_present, dside_local_present};
  wire logic [31:0] rd_word = sel_addr ? addr_q : sel_wdata ? wdata_q :
    sel_ctrl ? ctrl_word : sel_status ? status_word : sel_load ? load_q :
    sel_config ? config_word : 32'h0000_0000;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= `LMS_RST_WORD;
    end
    else
    begin
      pready_q <= apb_access;
      pslverr_q <= apb_access & ~hit;
      prdata_q <= (apb_access & ~pwrite) ? rd_word : `LMS_RST_WORD;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      addr_q <= `LMS_RST_WORD;
      wdata_q <= `LMS_RST_WORD;
      pend_q <= 1'b0;
      pend_cmd_q <= '0;
    end
    else
    begin
      addr_q <= (wr_take & sel_addr) ? pwdata : addr_q;
      wdata_q <= (wr_take & sel_wdata) ? pwdata : wdata_q;
      pend_q <= go_accept | (pend_q & ~launch);
      pend_cmd_q <= go_accept ? new_cmd : pend_cmd_q;
    end
  end

  // Sticky flags: a set in the clearing cycle wins
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      done_q <= 1'b0;
      refused_q <= 1'b0;
      load_q <= `LMS_RST_WORD;
    end
    else
    begin
      done_q <= done_now | (done_q & ~clr[`LMS_ST_DONE]);
      refused_q <= launch_bad | go_refuse | (refused_q & ~clr[`LMS_ST_REFUSED]);
      load_q <= (done_now & ~cur_wr_q) ? sif.load_val : load_q;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_q <= lms_pkg::LMS_IDLE;
      cur_iside_q <= 1'b0;
      cur_wr_q <= 1'b0;
      cur_lo_q <= 2'h0;
      cur_size_q <= `LMS_SIZE_BYTE;
    end
    else
    begin
      state_q <= state_d;
      cur_iside_q <= launch_ok ? pend_cmd_q.iside : cur_iside_q;
      cur_wr_q <= launch_ok ? pend_cmd_q.wr : cur_wr_q;
      cur_lo_q <= launch_ok ? addr_q[1:0] : cur_lo_q;
      cur_size_q <= launch_ok ? sif.cmd_size : cur_size_q;
    end
  end

  // ----------------------------------------
  // Local bus outputs, all active high
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      d_addr <= `LMS_RST_WORD;
      d_lane_sel <= 4'h0;
      d_wdata <= `LMS_RST_WORD;
      d_transfer_start_strobe <= 1'b0;
      d_rd_strobe <= 1'b0;
      d_wr_strobe <= 1'b0;
    end
    else
    begin
      d_addr <= launch_d ? addr_q : d_addr;
      d_lane_sel <= launch_d ? sif.lane_sel : d_lane_sel;
      d_wdata <= launch_wr ? sif.store_lanes : d_wdata;
      d_transfer_start_strobe <= launch_d;
      d_rd_strobe <= launch_rd | (d_rd_strobe & ~d_ready);
      d_wr_strobe <= launch_wr | (d_wr_strobe & ~d_ready);
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      i_addr <= `LMS_RST_WORD;
      i_transfer_start_strobe <= 1'b0;
      i_fetch_strobe <= 1'b0;
    end
    else
    begin
      i_addr <= launch_i ? addr_q : i_addr;
      i_transfer_start_strobe <= launch_i;
      i_fetch_strobe <= launch_i | (i_fetch_strobe & ~i_ready);
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  chk_start_single: assert property (
    d_transfer_start_strobe && !d_ready |=> !d_transfer_start_strobe)
    else $error("start strobe held past first cycle");

  chk_rd_fall: assert property (
    $fell(d_rd_strobe) |-> $past(d_ready))
    else $error("read strobe fell without ready");

  chk_rd_b2b: assert property (
    d_rd_strobe && d_ready && launch_rd |=> d_rd_strobe && d_transfer_start_strobe)
    else $error("read strobe dropped between back to back reads");

  chk_wr_fall: assert property (
    d_wr_strobe && !d_ready |=> d_wr_strobe)
    else $error("write strobe fell before ready");

  chk_wr_b2b: assert property (
    d_wr_strobe && d_ready && launch_wr |=> d_wr_strobe && d_transfer_start_strobe)
    else $error("write strobe dropped between back to back writes");

  chk_wdata_hold: assert property (
    d_wr_strobe && !d_ready |=> $stable(d_wdata))
    else $error("store data changed before ready");

  chk_lane_legal: assert property (
    d_transfer_start_strobe |-> d_lane_sel inside {4'h1, 4'h2, 4'h4, 4'h8, 4'h3, 4'hc, 4'hf})
    else $error("illegal lane select");

  chk_load_zero: assert property (
    done_now && !cur_wr_q && cur_size_q == `LMS_SIZE_BYTE |=> load_q[31:8] == 24'h00_0000)
    else $error("byte load not zero filled");

  chk_refuse_wide: assert property (
    launch_bad |=> refused_q && !d_transfer_start_strobe && !i_transfer_start_strobe)
    else $error("unsupported transfer was issued");

  chk_fetch_end: assert property (
    i_fetch_strobe && i_ready && !launch_i |=> !i_fetch_strobe)
    else $error("fetch strobe outlived ready");

  chk_apb_ready: assert property (
    apb_access |=> pready_q ##1 !pready_q)
    else $error("apb ready not a single cycle");

  chk_istart_single: assert property (
    i_transfer_start_strobe && !i_ready |=> !i_transfer_start_strobe)
    else $error("fetch start strobe held past first cycle");

  chk_half_zero: assert property (
    done_now && !cur_wr_q && cur_size_q == `LMS_SIZE_HALF |=> load_q[31:16] == 16'h0000)
    else $error("halfword load not zero filled");

  // Mixed back to back must hand over, never overlap
  chk_rw_apart: assert property (
    !(d_rd_strobe && d_wr_strobe))
    else $error("read and write strobes both high");

  cov_read: cover property (launch_rd ##[1:8] (d_rd_strobe && d_ready));
  cov_write: cover property (launch_wr ##[1:8] (d_wr_strobe && d_ready));
  cov_rd_b2b: cover property (d_rd_strobe && d_ready && launch_rd);
  cov_refuse: cover property (launch_bad);
  cov_fetch: cover property (launch_i ##[1:8] (i_fetch_strobe && i_ready));

endmodule // lms_master

// [src/lms_regs.svh]
`ifndef LMS_REGS_SVH
`define LMS_REGS_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define LMS_OFF_ADDR 12'h000
`define LMS_OFF_WDATA 12'h004
`define LMS_OFF_CTRL 12'h008
`define LMS_OFF_STATUS 12'h00c
`define LMS_OFF_LOAD 12'h010
`define LMS_OFF_CONFIG 12'h014

// ----------------------------------------
// Field positions
// ----------------------------------------
`define LMS_CTRL_GO 0
`define LMS_CTRL_WR 1
`define LMS_CTRL_SIZE 2
`define LMS_CTRL_TGT 4
`define LMS_CTRL_ISIDE 6
`define LMS_ST_BUSY 0
`define LMS_ST_DONE 1
`define LMS_ST_REFUSED 2
`define LMS_ST_PEND 3

// ----------------------------------------
// Encodings and reset values
// ----------------------------------------
`define LMS_SIZE_BYTE 2'h0
`define LMS_SIZE_HALF 2'h1
`define LMS_SIZE_WORD 2'h2
`define LMS_TGT_W32 2'h0
`define LMS_TGT_W16 2'h1
`define LMS_TGT_W8 2'h2
`define LMS_LANE_BYTE 4'h8
`define LMS_LANE_HALF 4'hc
`define LMS_LANE_WORD 4'hf
`define LMS_DATA_W 32
`define LMS_RST_WORD 32'h0000_0000

`endif

// [src/lms_pkg.sv]
package lms_pkg;

  typedef logic [1:0] lms_size_t;

  typedef enum logic [0:0] {LMS_IDLE, LMS_XFER} lms_state_e;

  typedef struct packed {
    logic iside;
    logic [1:0] tgt;
    lms_size_t size;
    logic wr;
  } lms_cmd_s;

endpackage

// [src/lms_steer_if.sv]
`timescale 1ns/1ps

interface lms_steer_if;
  logic [1:0] cmd_lo;
  lms_pkg::lms_size_t cmd_size;
  logic [1:0] cmd_tgt;
  logic [31:0] store_src;
  logic [3:0] lane_sel;
  logic [31:0] store_lanes;
  logic bad;
  logic [1:0] rsp_lo;
  lms_pkg::lms_size_t rsp_size;
  logic [31:0] rsp_lanes;
  logic [31:0] load_val;

  modport core (
    output cmd_lo,
    output cmd_size,
    output cmd_tgt,
    output store_src,
    output rsp_lo,
    output rsp_size,
    output rsp_lanes,
    input lane_sel,
    input store_lanes,
    input bad,
    input load_val
  );

  modport steer (
    input cmd_lo,
    input cmd_size,
    input cmd_tgt,
    input store_src,
    input rsp_lo,
    input rsp_size,
    input rsp_lanes,
    output lane_sel,
    output store_lanes,
    output bad,
    output load_val
  );
endinterface

// [src/lms_steer.sv]
`timescale 1ns/1ps
`include "lms_regs.svh"

module lms_steer (
  lms_steer_if.steer sif
);

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // Lane 0 is the most significant byte
  function automatic logic [7:0] lane_byte(input logic [31:0] w, input logic [1:0] k);
    case (k)
      2'h0: lane_byte = w[31:24];
      2'h1: lane_byte = w[23:16];
      2'h2: lane_byte = w[15:8];
      default: lane_byte = w[7:0];
    endcase
  endfunction

  function automatic logic [31:0] lane_mask(input logic [3:0] sel);
    lane_mask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
  endfunction

  // ----------------------------------------
  // Lane selects and legality
  // ----------------------------------------
  wire logic is_byte = (sif.cmd_size == `LMS_SIZE_BYTE);
  wire logic is_half = (sif.cmd_size == `LMS_SIZE_HALF);
  wire logic is_word = (sif.cmd_size == `LMS_SIZE_WORD);
  wire logic misaligned = (is_half & sif.cmd_lo[0]) | (is_word & (sif.cmd_lo != 2'h0));
  // No conversion cycles: too wide for the target is refused whole
  wire logic too_wide = ((sif.cmd_tgt == `LMS_TGT_W16) & is_word) |
    ((sif.cmd_tgt == `LMS_TGT_W8) & ~is_byte) | (sif.cmd_tgt == 2'h3);
  assign sif.bad = misaligned | too_wide | (sif.cmd_size == 2'h3);

  // Narrow targets use the lanes their offset selects, offset 0 on lane 0
  assign sif.lane_sel = is_byte ? (`LMS_LANE_BYTE >> sif.cmd_lo) :
    is_half ? (`LMS_LANE_HALF >> sif.cmd_lo) : `LMS_LANE_WORD;

  // Unselected lanes are driven zero, never meaningful
  wire logic [31:0] store_rep = is_byte ? {4{sif.store_src[7:0]}} :
    is_half ? {2{sif.store_src[15:0]}} : sif.store_src;
  assign sif.store_lanes = store_rep & lane_mask(sif.lane_sel);

  // ----------------------------------------
  // Load steering
  // ----------------------------------------
  wire logic [15:0] half_sel = sif.rsp_lo[1] ? sif.rsp_lanes[15:0] : sif.rsp_lanes[31:16];
  assign sif.load_val = (sif.rsp_size == `LMS_SIZE_BYTE) ?
    {24'h00_0000, lane_byte(sif.rsp_lanes, sif.rsp_lo)} :
    (sif.rsp_size == `LMS_SIZE_HALF) ? {16'h0000, half_sel} : sif.rsp_lanes;

endmodule // lms_steer

// [verif/lms_mem_model.sv]
`timescale 1ns/1ps

module lms_mem_model #(
  parameter logic [31:0] fill = 32'h0
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [3:0] lat,
  input wire logic [31:0] addr,
  input wire logic [3:0] lane_sel,
  input wire logic [31:0] wdata,
  input wire logic start,
  input wire logic wr,
  output logic [31:0] rdata,
  output logic ready
);
  logic [31:0] mem_q [0:15];
  logic [3:0] a_q, be_q, cnt_q;
  logic busy_q, wr_q;

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      for (int i = 0; i < 16; i++)
        mem_q[i] <= fill ^ 32'(i);
      {a_q, be_q, cnt_q, busy_q, wr_q, ready} <= '0;
      rdata <= '0;
    end
    else
    begin
      ready <= 1'b0;
      // Released bus toggles so stale data never looks valid
      rdata <= ~rdata;
      if (start)
      begin
        a_q <= addr[5:2];
        be_q <= lane_sel;
        wr_q <= wr;
        cnt_q <= lat;
        busy_q <= 1'b1;
      end
      else if (busy_q && cnt_q != 4'h0)
        cnt_q <= cnt_q - 4'h1;
      else if (busy_q)
      begin
        busy_q <= 1'b0;
        ready <= 1'b1;
        if (!wr_q)
          rdata <= mem_q[a_q];
        for (int b = 0; b < 4; b++)
          if (wr_q && be_q[b])
            mem_q[a_q][8*b +: 8] <= wdata[8*b +: 8];
      end
    end
endmodule // lms_mem_model

// [verif/lms_master_tb.sv]
`timescale 1ns/1ps
`include "lms_regs.svh"

module lms_master_tb;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err, rp, wp;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdv, st, cap_wd, cap_a, cap_ia;
  logic [31:0] d_addr, d_wdata, d_rdata, i_addr, i_rdata;
  logic [3:0] d_lane_sel, cap_be, dlat;
  logic d_start, d_rd, d_wr, d_ready, i_start, i_fetch, i_ready;
  int fails, tests_run, starts, istarts, rrise, wrise, cyc;

  lms_master DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .d_addr(d_addr), .d_lane_sel(d_lane_sel), .d_wdata(d_wdata),
    .d_transfer_start_strobe(d_start), .d_rd_strobe(d_rd), .d_wr_strobe(d_wr),
    .d_rdata(d_rdata), .d_ready(d_ready), .i_addr(i_addr),
    .i_transfer_start_strobe(i_start), .i_fetch_strobe(i_fetch), .i_rdata(i_rdata),
    .i_ready(i_ready));

  lms_mem_model dmem (.pclk(pclk), .presetn(presetn), .lat(dlat), .addr(d_addr),
    .lane_sel(d_lane_sel), .wdata(d_wdata), .start(d_start), .wr(d_wr),
    .rdata(d_rdata), .ready(d_ready));

  lms_mem_model #(.fill(32'h5a00_0000)) imem (.pclk(pclk), .presetn(presetn),
    .lat(4'h0), .addr(i_addr), .lane_sel(4'hf), .wdata(32'h0), .start(i_start),
    .wr(1'b0), .rdata(i_rdata), .ready(i_ready));

  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      fails++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // Sampled before the edge's updates land
  always @(posedge pclk)
  begin
    cyc++;
    if (d_start === 1'b1)
    begin
      starts++;
      {cap_be, cap_wd, cap_a} = {d_lane_sel, d_wdata, d_addr};
    end
    if (i_start === 1'b1)
    begin
      istarts++;
      cap_ia = i_addr;
    end
    rrise += int'(d_rd === 1'b1 && rp === 1'b0);
    wrise += int'(d_wr === 1'b1 && wp === 1'b0);
    {rp, wp} = {d_rd, d_wr};
    if (d_ready === 1'b1 && d_wr === 1'b1)
      chk(d_wdata, cap_wd);
    if (cyc == 30000)
    begin
      fails++;
      conclude();
    end
  end

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    // Only the cycle ceiling ends a wait that never sees ready
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    {rdv, err} = {prdata, pslverr};
    {psel, penable} <= 2'b00;
    @(posedge pclk);
  endtask

  task automatic wr32(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd32(input logic [11:0] a);
    apb(1'b0, a, 32'h0);
  endtask

  function automatic logic [31:0] cmd(input int w, input int sz, input int tg, input int is);
    return {25'h0, is[0], tg[1:0], sz[1:0], w[0], 1'b1};
  endfunction

  task automatic wait_idle();
    do
      rd32(`LMS_OFF_STATUS);
    while ((rdv & 32'h9) !== 32'h0);
    st = rdv;
    wr32(`LMS_OFF_STATUS, 32'h6);
  endtask

  task automatic xfer(input logic [31:0] a, input logic [31:0] d, input logic [31:0] c);
    wr32(`LMS_OFF_ADDR, a);
    wr32(`LMS_OFF_WDATA, d);
    wr32(`LMS_OFF_CTRL, c);
    wait_idle();
  endtask

  task automatic t_reset();
    chk({27'h0, d_start, d_rd, d_wr, i_start, i_fetch}, 32'h0);
    rd32(`LMS_OFF_CONFIG);
    chk(rdv, 32'h0000_200f);
    rd32(12'h018);
    chk(rdv ^ 32'(err), 32'h1);
    $display("reset and config done");
  endtask

  task automatic t_steer();
    logic [1:0] sz, lo;
    logic [3:0] be;
    logic [31:0] m, rep;
    int sh;
    logic [27:0] tab;
    // Lane selects written out per case, one nibble per scenario step
    tab = 28'hfc3_8421;
    xfer(32'h20, 32'haabb_ccdd, cmd(1, 2, 0, 0));
    for (int i = 0; i < 7; i++)
    begin
      sz = (i < 4) ? 2'h0 : (i < 6) ? 2'h1 : 2'h2;
      lo = (i < 4) ? 2'(3 - i) : (i == 4) ? 2'h2 : 2'h0;
      be = tab[4*i +: 4];
      m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
      rep = (sz == 2'h0) ? {4{8'h44}} : (sz == 2'h1) ? {2{16'h3344}} : 32'h1122_3344;
      sh = (sz == 2'h0) ? 8 * (3 - int'(lo)) : (sz == 2'h1) ? 8 * (2 - int'(lo)) : 0;
      xfer(32'h10, 32'haabb_ccdd, cmd(1, 2, 0, 0));
      xfer(32'h10 | lo, 32'h1122_3344, cmd(1, sz, 2 - sz, 0));
      chk(cap_be, be);
      chk(cap_a, 32'h10 | lo);
      chk(cap_wd, rep & m);
      xfer(32'h10, 32'h0, cmd(0, 2, 0, 0));
      rd32(`LMS_OFF_LOAD);
      chk(rdv, 32'haabb_ccdd & ~m | rep & m);
      xfer(32'h20 | lo, 32'h0, cmd(0, sz, 2 - sz, 0));
      rd32(`LMS_OFF_LOAD);
      chk(rdv, (32'haabb_ccdd >> sh) & ~(32'hffff_ffff << (8 << sz)));
    end
    $display("steering done");
  endtask

  task automatic t_refuse();
    logic [31:0] bad [6];
    int s0;
    bad = '{cmd(0, 1, 0, 0), cmd(0, 2, 1, 0), cmd(0, 1, 2, 0), cmd(0, 3, 0, 0),
            cmd(0, 0, 3, 0), cmd(1, 2, 0, 1)};
    s0 = starts + istarts;
    for (int i = 0; i < 6; i++)
    begin
      xfer((i == 0) ? 32'h11 : 32'h10, 32'h0, bad[i]);
      chk(st & 32'h4, 32'h4);
    end
    chk(32'(starts + istarts), 32'(s0));
    $display("refusals done");
  endtask

  task automatic t_b2b();
    int r0, w0;
    dlat <= 4'h6;
    wr32(`LMS_OFF_ADDR, 32'h20);
    wr32(`LMS_OFF_WDATA, 32'haabb_ccdd);
    for (int k = 0; k < 2; k++)
    begin
      {r0, w0} = {rrise, wrise};
      repeat (3) wr32(`LMS_OFF_CTRL, cmd(k, 2, 0, 0));
      wait_idle();
      chk(st & 32'h6, 32'h6);
      chk(32'((k == 0) ? rrise - r0 : wrise - w0), 32'h1);
    end
    rd32(`LMS_OFF_LOAD);
    chk(rdv, 32'haabb_ccdd);
    dlat <= 4'h0;
    $display("back to back done");
  endtask

  task automatic t_iside();
    xfer(32'h8, 32'h0, cmd(0, 2, 0, 1));
    chk(cap_ia, 32'h8);
    rd32(`LMS_OFF_LOAD);
    chk(rdv, 32'h5a00_0002);
    $display("instruction side done");
  endtask

  initial
  begin
    {presetn, psel, penable, pwrite, paddr, pwdata, dlat} = '0;
    {fails, tests_run, starts, istarts, rrise, wrise, cyc} = '0;
    {rp, wp} = 2'b00;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_steer();
    t_refuse();
    t_b2b();
    t_iside();
    conclude();
  end
endmodule // lms_master_tb
